//--- test/sadc_ctrl_bench.sv
// self-checking bench of the converter control top
`timescale 1ns/10ps
module sadc_ctrl_bench;
  reg clk_sys = 0;
  reg rst_n = 0;
  reg on = 1;
  reg en = 1;
  reg gs = 0;
  reg gc = 0;
  reg dc = 0;
  reg [3:0] ch = 0;
  reg [1:0] rs = 0;
  reg [2:0] cc = 0;
  reg [111:0] ain = 0;
  wire go, df, dp, wk;
  wire [7:0] res, pos, neg;
  integer bad_count = 0;
  integer num_checks = 0;
  integer i;
  sadc_ctrl u_sadc_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(en), .converter_on(on),
    .go_set(gs), .go_clear(gc), .done_flag_clear(dc), .channel_select(ch),
    .reference_select(rs), .conv_clock_select(cc), .analog_in(ain),
    .fixed_voltage_ref(8'hc3), .ext_ref(8'h9a), .supply_ref(8'hff),
    .convert_go_flag(go), .conversion_done_flag(df), .conversion_result(res),
    .done_pulse(dp), .wake_req(wk), .pos_ref_out(pos), .neg_ref_out(neg));
  // 125 MHz clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task step;
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task cmp(input [8*5-1:0] nm, input [7:0] exp, input [7:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // successive approximation, a trial bit kept while trial*ref/256 <= level
  function [7:0] sar(input [7:0] lv, input [7:0] rf);
    integer b, r, t;
    begin
      r = 0;
      for (b = 7; b >= 0; b = b - 1) begin
        t = r + (1 << b);
        if ((t * rf) / 256 <= lv) r = t;
      end
      sar = r;
    end
  endfunction
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // one conversion; n is clocks per bit period
  task run(input [3:0] c, input [1:0] r, input [2:0] k, input [7:0] ex, input [7:0] rv,
    input integer n);
    integer w;
    begin
      ch = c;
      rs = r;
      cc = k;
      dc = 1;
      step;
      dc = 0;
      gs = 1;
      step;
      gs = 0;
      w = 1;
      while (dp !== 1'b1 && w < 3000) begin
        step;
        w = w + 1;
      end
      if (w >= 3000) begin
        bad_count = bad_count + 1;
        test_done;
      end
      cmp("len", 8'h01, {7'h00, w >= 10 * n && w <= 11 * n + 4});
      cmp("res", ex, res);
      cmp("flag", 8'h01, {7'h00, df});
      cmp("go", 8'h00, {7'h00, go});
      cmp("pos", rv, pos);
      cmp("neg", 8'h00, neg);
      step;
      cmp("wake", 8'h01, {7'h00, wk});
      $display("test run done ch %h", c);
    end
  endtask
  // refused start, clear of flag, abort and reset mid-run
  task misc;
    begin
      dc = 1;
      on = 0;
      step;
      dc = 0;
      gs = 1;
      step;
      gs = 0;
      step;
      cmp("refu", 8'h00, {6'h00, go, df});
      cmp("wake", 8'h00, {7'h00, wk});
      on = 1;
      gs = 1;
      step;
      gs = 0;
      repeat (20) step;
      gc = 1;
      for (i = 0; i < 8 && go === 1'b1; i = i + 1) step;
      gc = 0;
      step;
      cmp("abrt", 8'h01, {6'h00, go, df});
      en = 0;
      gs = 1;
      step;
      gs = 0;
      step;
      cmp("frz", 8'h00, {7'h00, go});
      en = 1;
      gs = 1;
      step;
      gs = 0;
      repeat (5) step;
      rst_n = 0;
      step;
      cmp("rst", 8'h00, res | {6'h00, go, df});
      rst_n = 1;
      $display("test misc done");
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (i = 0; i < 14; i = i + 1) ain[8 * i +: 8] = 9 * i + 5;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1;
    step;
    run(4'h0, 2'h0, 3'h0, sar(8'h05, 8'hff), 8'hff, 2);
    run(4'hd, 2'h1, 3'h4, sar(8'h7a, 8'hff), 8'hff, 4);
    run(4'hf, 2'h2, 3'h1, sar(8'hc3, 8'h9a), 8'h9a, 8);
    run(4'he, 2'h3, 3'h5, 8'h00, 8'hc3, 16);
    run(4'h7, 2'h2, 3'h2, sar(8'h44, 8'h9a), 8'h9a, 32);
    run(4'h2, 2'h3, 3'h6, sar(8'h17, 8'hc3), 8'hc3, 64);
    run(4'h1, 2'h0, 3'h3, sar(8'h0e, 8'hff), 8'hff, 200);
    run(4'h1, 2'h0, 3'h7, sar(8'h0e, 8'hff), 8'hff, 200);
    misc;
    test_done;
  end
endmodule

//--- test/sadc_ctrl_properties.sv
// timing and status checker bound to the converter control top
`timescale 1ns/10ps
module sadc_ctrl_properties (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // controls
  input wire clk_en,
  input wire converter_on,
  input wire go_set,
  input wire go_clear,
  input wire done_flag_clear,
  input wire [2:0] conv_clock_select,
  // status
  input wire convert_go_flag,
  input wire conversion_done_flag,
  input wire [7:0] conversion_result,
  input wire done_pulse,
  input wire wake_req,
  input wire [7:0] neg_ref_out
);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // a start that the block must take
  sequence start_ok;
    clk_en && converter_on && go_set && !go_clear && !convert_go_flag && !done_pulse;
  endsequence
  // go stays up sixteen cycles, short of the twenty that ten ticks of two clocks take
  sequence run16;
    convert_go_flag [*8] ##1 convert_go_flag [*8];
  endsequence
  chk_go_start: assert property (start_ok |=> convert_go_flag)
    else $error("start not taken");
  chk_run_length: assert property ($rose(convert_go_flag) && conv_clock_select == 3'h0
    |-> run16 ##[1:12] done_pulse)
    else $error("conversion length wrong at divide by two");
  chk_go_end: assert property ($fell(convert_go_flag) && !$past(go_clear) && $past(converter_on)
    |-> done_pulse)
    else $error("go fell without completion");
  chk_pulse_once: assert property (done_pulse |=> !done_pulse)
    else $error("done pulse longer than one cycle");
  chk_done_status: assert property (done_pulse |-> conversion_done_flag && !convert_go_flag)
    else $error("status wrong at completion");
  chk_flag_sticky: assert property (conversion_done_flag && !done_flag_clear
    |=> conversion_done_flag)
    else $error("done flag dropped by itself");
  chk_wake_req: assert property (done_pulse |-> ##[0:1] wake_req)
    else $error("no wake request at completion");
  chk_result_hold: assert property (!$stable(conversion_result) |-> !convert_go_flag
    && ($past(convert_go_flag) || $past(convert_go_flag, 2)))
    else $error("result changed outside a conversion end");
  chk_neg_ground: assert property (neg_ref_out == 8'h00)
    else $error("negative reference not ground");
endmodule
bind sadc_ctrl sadc_ctrl_properties u_sadc_ctrl_properties (.clk_sys(clk_sys), .rst_n(rst_n),
  .clk_en(clk_en), .converter_on(converter_on), .go_set(go_set), .go_clear(go_clear),
  .done_flag_clear(done_flag_clear), .conv_clock_select(conv_clock_select),
  .convert_go_flag(convert_go_flag), .conversion_done_flag(conversion_done_flag),
  .conversion_result(conversion_result), .done_pulse(done_pulse), .wake_req(wake_req),
  .neg_ref_out(neg_ref_out));

//--- verilog/sadc_chan_mux.v
// input channel and positive reference selection
`timescale 1ns/10ps
`include "sadc_defs.vh"
module sadc_chan_mux (
  // selections
  input wire [3:0] channel_select,
  input wire [1:0] reference_select,
  // digitised analog levels
  input wire [111:0] analog_in,
  input wire [7:0] fixed_voltage_ref,
  input wire [7:0] ext_ref,
  input wire [7:0] supply_ref,
  // results
  output reg [7:0] sel_level,
  output reg [7:0] pos_ref,
  output reg chan_valid
);
  // pick one of fourteen pins or the fixed reference
  always @* begin
    sel_level = 8'h00;
    chan_valid = 1'b1;
    if (channel_select <= `SADC_CH_LAST_PIN)
      sel_level = analog_in[channel_select*8 +: 8];
    else if (channel_select == `SADC_CH_FVR)
      sel_level = fixed_voltage_ref;
    else
      chan_valid = 1'b0; // reserved code: no input
  end

  // positive reference; negative is ground always
  always @* begin
    if (reference_select == `SADC_REF_FVR)
      pos_ref = fixed_voltage_ref;
    else if (reference_select == `SADC_REF_EXT)
      pos_ref = ext_ref;
    else
      pos_ref = supply_ref;
  end
endmodule

//--- verilog/sadc_ctrl.v
// top of the converter control: sample-hold, sequencer and result
`timescale 1ns/10ps
`include "sadc_defs.vh"
module sadc_ctrl (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  // control bits from software
  input wire converter_on,
  input wire go_set,
  input wire go_clear,
  input wire done_flag_clear,
  input wire [3:0] channel_select,
  input wire [1:0] reference_select,
  input wire [2:0] conv_clock_select,
  // analog levels, digitised for modelling
  input wire [111:0] analog_in,
  input wire [7:0] fixed_voltage_ref,
  input wire [7:0] ext_ref,
  input wire [7:0] supply_ref,
  // status to software
  output reg convert_go_flag,
  output reg conversion_done_flag,
  output reg [7:0] conversion_result,
  output reg done_pulse,
  output reg wake_req,
  // reference routing seen by the analog core
  output reg [7:0] pos_ref_out,
  output reg [7:0] neg_ref_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [3:0] tick_cnt_r;
  reg [7:0] held_r;
  reg [7:0] sar_r;
  reg [7:0] trial_r;
  reg [7:0] ref_r;
  reg chan_ok_r;
  wire tick;
  wire [7:0] sel_level;
  wire [7:0] pos_ref;
  wire chan_valid;
  wire running;
  wire [15:0] scaled;
  wire [7:0] cmp_level;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  assign running = (state_r == ST_CONV);

  // bit-period timebase
  sadc_tick_div u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .run(running),
    .conv_clock_select(conv_clock_select),
    .tick_r(tick)
  );

  // channel and reference selection
  sadc_chan_mux u_mux (
    .channel_select(channel_select),
    .reference_select(reference_select),
    .analog_in(analog_in),
    .fixed_voltage_ref(fixed_voltage_ref),
    .ext_ref(ext_ref),
    .supply_ref(supply_ref),
    .sel_level(sel_level),
    .pos_ref(pos_ref),
    .chan_valid(chan_valid)
  );

  // ----------------------------------------
  // comparator against the trial code
  // ----------------------------------------
  // compare held level against trial fraction of the positive reference
  assign scaled = trial_r * ref_r;
  assign cmp_level = scaled[15:8];

  // ----------------------------------------
  // sequencer next state
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (go_set && converter_on)
          state_nxt = ST_CONV;
      end
      ST_CONV: begin
        if (!converter_on || go_clear)
          state_nxt = ST_DONE;
        else if (tick && tick_cnt_r == `SADC_CONV_TICKS - 4'h1)
          state_nxt = ST_DONE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // sequencer registers
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      tick_cnt_r <= 4'h0;
      held_r <= 8'h00;
      sar_r <= 8'h00;
      trial_r <= 8'h80;
      ref_r <= 8'h00;
      chan_ok_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && state_nxt == ST_CONV) begin
        // sample-and-hold captures the routed input once
        held_r <= sel_level;
        chan_ok_r <= chan_valid;
        ref_r <= pos_ref;
        sar_r <= 8'h00;
        trial_r <= 8'h80;
        tick_cnt_r <= 4'h0;
      end else if (running && tick) begin
        tick_cnt_r <= tick_cnt_r + 4'h1;
        // ticks 1..8 resolve one bit each, msb first; first tick is acquisition
        if (tick_cnt_r >= 4'h1 && tick_cnt_r <= 4'h8) begin
          if (chan_ok_r && held_r >= cmp_level)
            sar_r <= trial_r;
          else
            sar_r <= trial_r & ~bit_mask(tick_cnt_r);
          trial_r <= (held_r >= cmp_level && chan_ok_r) ?
            (trial_r | (bit_mask(tick_cnt_r) >> 1)) :
            ((trial_r & ~bit_mask(tick_cnt_r)) | (bit_mask(tick_cnt_r) >> 1));
        end
      end
    end
  end

  // one-hot mask of the bit under trial
  function [7:0] bit_mask;
    input [3:0] idx;
    begin
      bit_mask = 8'h80 >> (idx - 4'h1);
    end
  endfunction

  // ----------------------------------------
  // status, result and flags
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      convert_go_flag <= 1'b0;
      conversion_done_flag <= 1'b0;
      conversion_result <= `SADC_RESULT_RST;
      done_pulse <= 1'b0;
      wake_req <= 1'b0;
      pos_ref_out <= 8'h00;
      neg_ref_out <= 8'h00;
    end else if (clk_en) begin
      pos_ref_out <= pos_ref;
      neg_ref_out <= 8'h00;
      done_pulse <= 1'b0;
      if (state_r == ST_IDLE && state_nxt == ST_CONV)
        convert_go_flag <= 1'b1;
      else if (state_r == ST_DONE)
        convert_go_flag <= 1'b0;
      if (state_r == ST_DONE) begin
        // aborted runs keep resolved bits; others follow the last decided bit
        conversion_result <= sar_r;
        done_pulse <= 1'b1;
        conversion_done_flag <= 1'b1;
        wake_req <= 1'b1;
      end else if (done_flag_clear) begin
        conversion_done_flag <= 1'b0; // set wins over clear
        wake_req <= 1'b0;
      end
    end
  end
endmodule

//--- verilog/sadc_defs.vh
// constants for the successive-approximation converter control block
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH
// ----------------------------------------
// conversion clock select codes
// ----------------------------------------
`define SADC_CCS_DIV2 3'h0
`define SADC_CCS_DIV4 3'h4
`define SADC_CCS_DIV8 3'h1
`define SADC_CCS_DIV16 3'h5
`define SADC_CCS_DIV32 3'h2
`define SADC_CCS_DIV64 3'h6
// ----------------------------------------
// channel and reference codes
// ----------------------------------------
`define SADC_CH_LAST_PIN 4'hd
`define SADC_CH_RESERVED 4'he
`define SADC_CH_FVR 4'hf
`define SADC_REF_SUPPLY 2'h0
`define SADC_REF_EXT 2'h2
`define SADC_REF_FVR 2'h3
// ----------------------------------------
// sequence and timing
// ----------------------------------------
`define SADC_RES_W 8
`define SADC_CONV_TICKS 4'ha
`define SADC_RESULT_RST 8'h00
`define SADC_RC_PERIOD_NS 1600
`define SADC_CLK_NS 8
`define SADC_RC_CYCLES (`SADC_RC_PERIOD_NS / `SADC_CLK_NS)
`define SADC_RC_LIMIT 8'hc7
`endif

//--- verilog/sadc_tick_div.v
// bit-period tick generator from divided system clock or local rc timer
`timescale 1ns/10ps
`include "sadc_defs.vh"
module sadc_tick_div (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  // control
  input wire run,
  input wire [2:0] conv_clock_select,
  // tick out
  output reg tick_r
);
  reg [7:0] cnt_r;
  reg [7:0] limit;

  // period count minus one per selection; divide by 2 gives one tick per two clocks
  always @* begin
    case (conv_clock_select)
      `SADC_CCS_DIV2: limit = 8'h01;
      `SADC_CCS_DIV4: limit = 8'h03;
      `SADC_CCS_DIV8: limit = 8'h07;
      `SADC_CCS_DIV16: limit = 8'h0f;
      `SADC_CCS_DIV32: limit = 8'h1f;
      `SADC_CCS_DIV64: limit = 8'h3f;
      default: limit = `SADC_RC_LIMIT; // x11: rc timer, rc cycles minus one
    endcase
  end

  // free count while a conversion runs, one tick per bit period
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_r <= 8'h00;
        tick_r <= 1'b0;
      end else if (cnt_r >= limit) begin
        cnt_r <= 8'h00;
        tick_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 8'h01;
        tick_r <= 1'b0;
      end
    end
  end
endmodule
